// ---- inc/itpim_pkg.sv ----
/*
  constants for the input test pulse and interlock monitor: timing figures
  in their own units and the cycle counts derived from the 25 MHz clock.
  assumes every user writes itpim_pkg::name, nothing is imported.
*/
package itpim_pkg;
  localparam int unsigned CLK_HZ = 25000000;
  // millisecond tick derived from the clock
  localparam int unsigned TICK_US = 1000;
  localparam int unsigned TICK_CYCLES = (CLK_HZ / 1000000) * TICK_US;
  // pulse timing in ms
  localparam int unsigned PULSE_WIDTH_TIME_MS = 2;
  localparam int unsigned PULSE_PERIOD_TIME_MS = 500;
  localparam int unsigned PULSE_RETURN_WINDOW_MS = 40;
  localparam int unsigned PULSE_PHASE_OFFSET_MS = 70;
  // phase of each channel within the period, at least the offset apart
  localparam int unsigned PHASE_FIRST_MS = 0;
  localparam int unsigned PHASE_SECOND_MS = 100;
  localparam int unsigned PHASE_START_MS = 200;
  // interlock timing in ms
  localparam int unsigned INTERLOCK_WINDOW_MS = 200;
  localparam int unsigned INTERLOCK_CLEAR_MS = 1000;
  // antivalent synchronization time in ms
  localparam int unsigned SYNC_TIME_MS = 500;
  // counter widths
  localparam int unsigned MS_W = 11;
  localparam int unsigned TICK_W = 15;
endpackage

// ---- rtl/itpim_ms_tick.sv ----
/*
  free-running millisecond tick generator.
  assumes one clock and a synchronous active low reset.
*/
`timescale 1ns/10ps
module itpim_ms_tick #(
  parameter int unsigned TICK_CYCLES = itpim_pkg::TICK_CYCLES
) (
  input wire logic clock_in,
  input wire logic rstn_in,
  output logic tick_out
);
  logic [itpim_pkg::TICK_W-1:0] count_r;

  // count one millisecond, pulse for one cycle at wrap
  always_ff @(posedge clock_in) begin
    if (!rstn_in) begin
      count_r <= '0;
      tick_out <= 1'b0;
    end else if (count_r == itpim_pkg::TICK_W'(TICK_CYCLES - 1)) begin
      count_r <= '0;
      tick_out <= 1'b1;
    end else begin
      count_r <= count_r + 1'b1;
      tick_out <= 1'b0;
    end
  end
endmodule

// ---- rtl/itpim_pulse_chan.sv ----
/*
  one dynamized channel: drives the test pulse on the control output and
  checks that it comes back on the sense input within the return window.
  assumes a one-cycle ms tick and a sense input already synchronised.
  drive is high when idle; the pulse pulls it low.
*/
`timescale 1ns/10ps
module itpim_pulse_chan #(
  parameter int unsigned PHASE_MS = 0,
  parameter int unsigned WIDTH_MS = itpim_pkg::PULSE_WIDTH_TIME_MS,
  parameter int unsigned PERIOD_MS = itpim_pkg::PULSE_PERIOD_TIME_MS,
  parameter int unsigned RETURN_MS = itpim_pkg::PULSE_RETURN_WINDOW_MS
) (
  input wire logic clock_in,
  input wire logic rstn_in,
  input wire logic enable_in,
  input wire logic tick_in,
  input wire logic sense_in,
  output logic drive_out,
  output logic fault_out
);
  localparam int unsigned W = itpim_pkg::MS_W;
  logic [W-1:0] phase_r;
  logic [W-1:0] since_r;
  logic checking_r;
  logic seen_r;

  // phase within the period, starting at this channel's offset
  always_ff @(posedge clock_in) begin
    if (!rstn_in) begin
      phase_r <= W'(PHASE_MS);
    end else if (tick_in) begin
      phase_r <= (phase_r == W'(PERIOD_MS - 1)) ? '0 : phase_r + 1'b1;
    end
  end

  // pulse low for the width at the start of each period
  always_ff @(posedge clock_in) begin
    if (!rstn_in) begin
      drive_out <= 1'b1;
    end else begin
      drive_out <= !(enable_in && (phase_r < W'(WIDTH_MS)));
    end
  end

  // watch the sense input for the pulse within the return window
  always_ff @(posedge clock_in) begin
    if (!rstn_in) begin
      since_r <= '0;
      checking_r <= 1'b0;
      seen_r <= 1'b0;
      fault_out <= 1'b0;
    end else if (!enable_in) begin
      checking_r <= 1'b0;
      seen_r <= 1'b0;
    end else if (tick_in && phase_r == '0) begin
      since_r <= '0;
      checking_r <= 1'b1;
      seen_r <= 1'b0;
      if (checking_r && !seen_r) begin
        fault_out <= 1'b1;
      end
    end else if (checking_r) begin
      if (!sense_in) begin
        seen_r <= 1'b1;
      end
      if (tick_in) begin
        since_r <= since_r + 1'b1;
        if (since_r == W'(RETURN_MS - 1)) begin
          checking_r <= 1'b0;
          fault_out <= fault_out || !(seen_r || !sense_in);
        end
      end
    end
  end
endmodule

// ---- rtl/itpim_monitor.sv ----
/*
  input test pulse and interlock monitor: pulses the first safety input, the second
  one outside antivalent mode, and the start input, checks the returns, checks antivalent synchronization
  and signal interlock, and gates the energize transition.
  assumes pins arrive asynchronously; the output stage lies outside.
*/
`timescale 1ns/10ps
module itpim_monitor #(
  parameter int unsigned SYNC_MS = itpim_pkg::SYNC_TIME_MS,
  parameter int unsigned TICK_CYCLES = itpim_pkg::TICK_CYCLES
) (
  input wire logic clock_in,
  input wire logic rstn_in,
  input wire logic dynamize_en_in,
  input wire logic interlock_en_in,
  input wire logic antivalent_en_in,
  input wire logic first_safety_sense_in,
  input wire logic second_safety_sense_in,
  input wire logic start_sense_in,
  output logic first_safety_drive_out,
  output logic second_safety_drive_out,
  output logic start_drive_out,
  output logic cross_fault_out,
  output logic interlock_alert_out,
  output logic sync_alert_out,
  output logic energize_transition_out
);
  localparam int unsigned W = itpim_pkg::MS_W;

  typedef enum logic [1:0] {
    ITPIM_IDLE,
    ITPIM_WINDOW,
    ITPIM_ALERT
  } itpim_state_t;

  logic [2:0] sync1_r;
  logic [2:0] sync2_r;
  logic tick;
  logic drv_first;
  logic drv_second;
  logic drv_start;
  logic flt_first;
  logic flt_second;
  logic flt_start;
  logic [W-1:0] il_count_r;
  logic [W-1:0] sync_count_r;
  logic [W-1:0] settle_count_r;
  itpim_state_t state_r;
  itpim_state_t state_nxt;
  logic first_act;
  logic second_act;
  logic first_act_r;
  logic second_act_r;
  logic first_seen_r;
  logic first_is_a_r;
  logic first_hold_r;
  logic second_hold_r;
  logic [2:0] first_hist_r;
  logic [2:0] second_hist_r;
  logic first_mask;
  logic second_mask;
  logic clear_done;
  logic all_active;

  // two-stage synchronisers for the three sense pins
  always_ff @(posedge clock_in) begin
    if (!rstn_in) begin
      sync1_r <= 3'h7;
      sync2_r <= 3'h7;
    end else begin
      sync1_r <= {start_sense_in, second_safety_sense_in, first_safety_sense_in};
      sync2_r <= sync1_r;
    end
  end

  itpim_ms_tick #(
    .TICK_CYCLES(TICK_CYCLES)
  ) u_tick (
    .clock_in(clock_in),
    .rstn_in(rstn_in),
    .tick_out(tick)
  );

  // the three pulse channels, phase shifted by 100 ms steps
  itpim_pulse_chan #(
    .PHASE_MS(itpim_pkg::PHASE_FIRST_MS)
  ) u_first (
    .clock_in(clock_in),
    .rstn_in(rstn_in),
    .enable_in(dynamize_en_in),
    .tick_in(tick),
    .sense_in(sync2_r[0]),
    .drive_out(drv_first),
    .fault_out(flt_first)
  );

  itpim_pulse_chan #(
    .PHASE_MS(itpim_pkg::PHASE_SECOND_MS)
  ) u_second (
    .clock_in(clock_in),
    .rstn_in(rstn_in),
    .enable_in(dynamize_en_in && !antivalent_en_in),
    .tick_in(tick),
    .sense_in(sync2_r[1]),
    .drive_out(drv_second),
    .fault_out(flt_second)
  );

  itpim_pulse_chan #(
    .PHASE_MS(itpim_pkg::PHASE_START_MS)
  ) u_start (
    .clock_in(clock_in),
    .rstn_in(rstn_in),
    .enable_in(1'b1),
    .tick_in(tick),
    .sense_in(sync2_r[2]),
    .drive_out(drv_start),
    .fault_out(flt_start)
  );

  // drives registered once more so outputs come straight from flops
  always_ff @(posedge clock_in) begin
    if (!rstn_in) begin
      first_safety_drive_out <= 1'b1;
      second_safety_drive_out <= 1'b1;
      start_drive_out <= 1'b1;
    end else begin
      first_safety_drive_out <= drv_first;
      second_safety_drive_out <= drv_second;
      start_drive_out <= drv_start;
    end
  end

  // sticky cross fault from any channel; cleared only by reset
  always_ff @(posedge clock_in) begin
    if (!rstn_in) begin
      cross_fault_out <= 1'b0;
    end else if (flt_first || flt_second || flt_start) begin
      cross_fault_out <= 1'b1;
    end
  end

  // activation decode: plain high-active or antivalent pair
  always_comb begin
    if (antivalent_en_in) begin
      first_act = !sync2_r[0] && sync2_r[1];
      second_act = first_act;
    end else begin
      first_act = sync2_r[0];
      second_act = sync2_r[1];
    end
  end

  // short history of each safety drive, covering the return lag through the pins
  always_ff @(posedge clock_in) begin
    if (!rstn_in) begin
      first_hist_r <= 3'h7;
      second_hist_r <= 3'h7;
    end else begin
      first_hist_r <= {first_hist_r[1:0], drv_first};
      second_hist_r <= {second_hist_r[1:0], drv_second};
    end
  end

  // a pulse is in flight from launch until its trailing edge left the synchroniser
  always_comb begin
    first_mask = !drv_first || (first_hist_r != 3'h7);
    if (antivalent_en_in) begin
      second_mask = first_mask; // both decodes read the pulsed first channel
    end else begin
      second_mask = !drv_second || (second_hist_r != 3'h7);
    end
  end

  // hold activation frozen while an own pulse is in flight
  always_ff @(posedge clock_in) begin
    if (!rstn_in) begin
      first_hold_r <= 1'b0;
      second_hold_r <= 1'b0;
      first_act_r <= 1'b0;
      second_act_r <= 1'b0;
    end else begin
      if (!first_mask) begin
        first_hold_r <= first_act;
      end
      if (!second_mask) begin
        second_hold_r <= second_act;
      end
      first_act_r <= first_mask ? first_hold_r : first_act;
      second_act_r <= second_mask ? second_hold_r : second_act;
    end
  end

  // antivalent equal-level timer
  always_ff @(posedge clock_in) begin
    if (!rstn_in) begin
      sync_count_r <= '0;
      sync_alert_out <= 1'b0;
    end else if (!antivalent_en_in || (sync2_r[0] != sync2_r[1])) begin
      sync_count_r <= '0;
    end else if (tick) begin
      if (sync_count_r >= W'(SYNC_MS - 1)) begin
        sync_alert_out <= 1'b1;
      end else begin
        sync_count_r <= sync_count_r + 1'b1;
      end
    end
  end

  assign all_active = first_act_r && second_act_r;
  assign clear_done = (settle_count_r >= W'(itpim_pkg::INTERLOCK_CLEAR_MS));

  // interlock state machine
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      ITPIM_IDLE: begin
        if (interlock_en_in && (first_act_r != second_act_r) && !first_seen_r) begin
          state_nxt = ITPIM_WINDOW;
        end
      end
      ITPIM_WINDOW: begin
        if (!interlock_en_in) begin
          state_nxt = ITPIM_IDLE;
        end else if (!first_act_r && !second_act_r) begin
          state_nxt = ITPIM_IDLE;
        end else if (first_act_r && second_act_r) begin
          state_nxt = ITPIM_ALERT;
        end else if (tick && il_count_r >= W'(itpim_pkg::INTERLOCK_WINDOW_MS - 1)) begin
          state_nxt = ITPIM_ALERT;
        end
      end
      ITPIM_ALERT: begin
        if (clear_done && !first_act_r && !second_act_r) begin
          state_nxt = ITPIM_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clock_in) begin
    if (!rstn_in) begin
      state_r <= ITPIM_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // window timer and memory of a pair already down
  always_ff @(posedge clock_in) begin
    if (!rstn_in) begin
      il_count_r <= '0;
      first_seen_r <= 1'b0;
      first_is_a_r <= 1'b0;
    end else begin
      if (state_r != ITPIM_WINDOW) begin
        il_count_r <= '0;
      end else if (tick) begin
        il_count_r <= il_count_r + 1'b1;
      end
      if (state_r == ITPIM_IDLE && state_nxt == ITPIM_WINDOW) begin
        first_is_a_r <= !first_act_r;
      end
      // both down once: a later single reactivation is not a new window
      if (!first_act_r && !second_act_r) begin
        first_seen_r <= 1'b1;
      end else if (all_active) begin
        first_seen_r <= 1'b0;
      end
    end
  end

  // one-second settle counter of both inputs deactivated
  always_ff @(posedge clock_in) begin
    if (!rstn_in) begin
      settle_count_r <= '0;
    end else if (first_act_r || second_act_r) begin
      settle_count_r <= '0;
    end else if (tick && !clear_done) begin
      settle_count_r <= settle_count_r + 1'b1;
    end
  end

  // alert and energize permission outputs
  always_ff @(posedge clock_in) begin
    if (!rstn_in) begin
      interlock_alert_out <= 1'b0;
      energize_transition_out <= 1'b0;
    end else begin
      interlock_alert_out <= (state_nxt == ITPIM_ALERT);
      energize_transition_out <= all_active && (state_nxt != ITPIM_ALERT)
        && !cross_fault_out && !sync_alert_out && !(flt_first || flt_second || flt_start);
    end
  end
endmodule

// ---- test/itpim_chk_monitor.sv ----
/*
  port checker for the monitor: pulse shape and spacing, alert sources,
  gating of the energize transition.
  assumes a bind onto itpim_monitor and a single clock domain.
*/
`timescale 1ns/10ps
module itpim_chk #(
  parameter int unsigned SYNC_MS = 500,
  parameter int unsigned TICK_CYCLES = 25000
) (
  input wire logic clock_in,
  input wire logic rstn_in,
  input wire logic dynamize_en_in,
  input wire logic interlock_en_in,
  input wire logic antivalent_en_in,
  input wire logic first_safety_sense_in,
  input wire logic second_safety_sense_in,
  input wire logic start_sense_in,
  input wire logic first_safety_drive_out,
  input wire logic second_safety_drive_out,
  input wire logic start_drive_out,
  input wire logic cross_fault_out,
  input wire logic interlock_alert_out,
  input wire logic sync_alert_out,
  input wire logic energize_transition_out
);
  localparam int LO_MIN = 2 * TICK_CYCLES - 2;
  localparam int LO_MAX = 2 * TICK_CYCLES + 2;
  logic [16:0] lo_cnt_r;
  default clocking @(posedge clock_in); endclocking
  default disable iff (!rstn_in);
  // counts the cycles the first drive sits low
  always_ff @(posedge clock_in) begin
    if (!rstn_in || first_safety_drive_out) lo_cnt_r <= 17'h00000;
    else lo_cnt_r <= lo_cnt_r + 17'h00001;
  end
  property p_width;
    $rose(first_safety_drive_out) |-> lo_cnt_r >= LO_MIN && lo_cnt_r <= LO_MAX;
  endproperty
  a_width: assert property (p_width) else $error("pulse width off");
  property p_apart;
    !(!first_safety_drive_out && !second_safety_drive_out);
  endproperty
  a_apart: assert property (p_apart) else $error("safety pulses overlap");
  property p_start_apart;
    !(!start_drive_out && !first_safety_drive_out);
  endproperty
  a_start_apart: assert property (p_start_apart) else $error("start pulse overlap");
  property p_fault_sticky;
    cross_fault_out |=> cross_fault_out;
  endproperty
  a_fault_sticky: assert property (p_fault_sticky) else $error("fault lost");
  property p_fault_off;
    cross_fault_out && $past(cross_fault_out) |-> !energize_transition_out;
  endproperty
  a_fault_off: assert property (p_fault_off) else $error("energized on fault");
  property p_alert_off;
    interlock_alert_out && $past(interlock_alert_out) |-> !energize_transition_out;
  endproperty
  a_alert_off: assert property (p_alert_off) else $error("energized on alert");
  property p_lock_src;
    $rose(interlock_alert_out) |-> $past(interlock_en_in);
  endproperty
  a_lock_src: assert property (p_lock_src) else $error("alert while off");
  property p_sync_src;
    $rose(sync_alert_out) |-> $past(antivalent_en_in);
  endproperty
  a_sync_src: assert property (p_sync_src) else $error("sync alert off mode");
  property p_deact;
    (!antivalent_en_in && first_safety_drive_out && !first_safety_sense_in)[*8]
      |-> !energize_transition_out;
  endproperty
  a_deact: assert property (p_deact) else $error("energized while off");
  // main scenarios reached
  c_pulse: cover property ($rose(first_safety_drive_out));
  c_energize: cover property ($rose(energize_transition_out));
  c_sync: cover property ($rose(sync_alert_out));
endmodule

bind itpim_monitor itpim_chk #(.SYNC_MS(SYNC_MS), .TICK_CYCLES(TICK_CYCLES)) u_chk (.clock_in,
  .rstn_in,
  .dynamize_en_in, .interlock_en_in, .antivalent_en_in, .first_safety_sense_in,
  .second_safety_sense_in, .start_sense_in, .first_safety_drive_out,
  .second_safety_drive_out, .start_drive_out, .cross_fault_out,
  .interlock_alert_out, .sync_alert_out, .energize_transition_out);

// ---- test/itpim_contacts.sv ----
/*
  external switch contacts: a closed contact loops its drive to the sense pin.
  assumes an open input is pulled down to low.
*/
`timescale 1ns/10ps
module itpim_contacts (
  input wire logic [2:0] drive_in,
  input wire logic [2:0] closed_in,
  input wire logic [2:0] stuck_in,
  output logic [2:0] sense_out
);
  // open contact lets the pull-down win; a stuck line models a short to supply
  assign sense_out = (drive_in & closed_in) | stuck_in;
endmodule

// ---- test/itpim_monitor_bench.sv ----
/*
  self-checking bench for the monitor with contact models on the pins.
  assumes the 25 MHz clock and a 2 ms synchronization time.
*/
`timescale 1ns/10ps
module itpim_monitor_bench;
  // ms tick shortened to 25 cycles so the whole run stays short
  localparam int TK = 25;
  logic clock_in = 1'b0;
  logic rstn_in = 1'b0;
  logic dynamize_en_in = 1'b1;
  logic interlock_en_in = 1'b0;
  logic antivalent_en_in = 1'b0;
  logic [2:0] closed = 3'h0;
  logic [2:0] stuck = 3'h0;
  wire first_safety_sense_in, second_safety_sense_in, start_sense_in;
  logic first_safety_drive_out, second_safety_drive_out, start_drive_out;
  logic cross_fault_out, interlock_alert_out, sync_alert_out, energize_transition_out;
  int n_mismatch = 0;
  int checks_done = 0;
  always #20 clock_in = ~clock_in;
  itpim_monitor #(.SYNC_MS(2), .TICK_CYCLES(TK)) u_dut (.clock_in, .rstn_in, .dynamize_en_in,
    .interlock_en_in, .antivalent_en_in, .first_safety_sense_in,
    .second_safety_sense_in, .start_sense_in, .first_safety_drive_out,
    .second_safety_drive_out, .start_drive_out, .cross_fault_out,
    .interlock_alert_out, .sync_alert_out, .energize_transition_out);
  itpim_contacts u_contacts (
    .drive_in({start_drive_out, second_safety_drive_out, first_safety_drive_out}),
    .closed_in(closed),
    .stuck_in(stuck),
    .sense_out({start_sense_in, second_safety_sense_in, first_safety_sense_in}));
  // compares and counts
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // waits n edges, then steps just past the edge
  task automatic step(input int n);
    repeat (n) @(posedge clock_in);
    #1;
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic t_reset;
    check({first_safety_drive_out, second_safety_drive_out, start_drive_out}, 32'h00000007);
    check({cross_fault_out, interlock_alert_out, sync_alert_out}, 32'h00000000);
    check(energize_transition_out, 32'h00000000);
    $display("test reset done");
  endtask
  // close, open one channel, close again
  task automatic t_energize;
    closed = 3'h7;
    step(3 * TK); // let the pulse launched at reset pass
    check(energize_transition_out, 32'h00000001);
    closed = 3'h6;
    step(12);
    check(energize_transition_out, 32'h00000000);
    closed = 3'h7;
    step(8);
    check(energize_transition_out, 32'h00000001);
    $display("test energize done");
  endtask
  // first pulse: width, spacing from the others, return seen
  task automatic t_pulse;
    int n;
    logic bad;
    n = 0;
    bad = 1'b0;
    while (first_safety_drive_out !== 1'b0 && n < itpim_pkg::PULSE_PERIOD_TIME_MS * TK) begin
      step(1);
      n++;
    end
    check(first_safety_drive_out, 32'h00000000);
    n = 0;
    while (first_safety_drive_out === 1'b0 && n < 3 * TK) begin
      if (second_safety_drive_out !== 1'b1 || start_drive_out !== 1'b1) bad = 1'b1;
      if (energize_transition_out !== 1'b1) bad = 1'b1;
      step(1);
      n++;
    end
    check(n >= 2 * TK - 2 && n <= 2 * TK + 2, 32'h00000001);
    check(bad, 32'h00000000);
    step(itpim_pkg::PULSE_RETURN_WINDOW_MS * TK);
    check(cross_fault_out, 32'h00000000);
    $display("test pulse done");
  endtask
  // interlock: early reactivation alerts at once, one second of rest clears it
  task automatic t_interlock;
    dynamize_en_in = 1'b0;
    interlock_en_in = 1'b1;
    step(8);
    closed = 3'h6;
    step(8);
    check(interlock_alert_out, 32'h00000000);
    closed = 3'h7;
    step(8);
    check(interlock_alert_out, 32'h00000001);
    check(energize_transition_out, 32'h00000000);
    closed = 3'h0;
    step((itpim_pkg::INTERLOCK_CLEAR_MS - 10) * TK);
    check(interlock_alert_out, 32'h00000001);
    step(20 * TK);
    check(interlock_alert_out, 32'h00000000);
    closed = 3'h7;
    step(8);
    check(energize_transition_out, 32'h00000001);
    $display("test interlock done");
  endtask
  // window expiry alerts after 200 ms; a start return shorted high latches a fault
  task automatic t_late;
    int n;
    antivalent_en_in = 1'b0;
    closed = 3'h7;
    step(8);
    closed = 3'h6;
    step((itpim_pkg::INTERLOCK_WINDOW_MS - 10) * TK);
    check(interlock_alert_out, 32'h00000000);
    step(20 * TK);
    check(interlock_alert_out, 32'h00000001);
    stuck = 3'h4;
    n = 0;
    while (cross_fault_out !== 1'b1 && n < 560 * TK) begin
      step(1);
      n++;
    end
    check(cross_fault_out, 32'h00000001);
    check(energize_transition_out, 32'h00000000);
    $display("test late done");
  endtask
  // antivalent activation, then equal levels held too long
  task automatic t_sync;
    int n;
    dynamize_en_in = 1'b0;
    antivalent_en_in = 1'b1;
    closed = 3'h6;
    step(8);
    check(energize_transition_out, 32'h00000001);
    closed = 3'h4;
    step(TK * 4 / 5);
    check(sync_alert_out, 32'h00000000);
    n = 0;
    while (sync_alert_out !== 1'b1 && n < 2 * TK) begin
      step(1);
      n++;
    end
    check(sync_alert_out, 32'h00000001);
    check(energize_transition_out, 32'h00000000);
    $display("test sync done");
  endtask
  initial begin
    step(2);
    rstn_in = 1'b1;
    t_reset();
    t_energize();
    t_pulse();
    t_interlock();
    t_sync();
    t_late();
    tally_and_finish();
  end
  // cuts a hang short
  initial begin
    repeat (2800 * TK) @(posedge clock_in);
    n_mismatch++;
    $display("watchdog expired");
    tally_and_finish();
  end
endmodule
